// file: common/eas_pkg.sv
// eas_pkg: shared constants and types for the event/action sequencer
// assumes: single 250 MHz clock domain; no software-visible registers
package eas_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int EAS_MAX_PAIRS = 20;
    localparam int EAS_IDX_W = 5;
    localparam int EAS_STAT_W = 8;
    localparam int EAS_NUM_CMP = 4;
    localparam int EAS_NUM_LR = 4;
    localparam int EAS_VAL_W = 16;
    localparam int EAS_ACT_W = 8;
    localparam int EAS_SRC_W = 5;
    localparam int EAS_LR_IN = 3;

    // ----------------------------------------
    // timing: scan interval
    // ----------------------------------------
    localparam int EAS_CLK_MHZ = 250;
    localparam int EAS_SCAN_US = 1;
    localparam int EAS_SCAN_CYC = EAS_SCAN_US * EAS_CLK_MHZ;

    localparam logic [EAS_IDX_W-1:0] EAS_IDX_ZERO = 5'h00;
    localparam logic [EAS_IDX_W-1:0] EAS_IDX_ONE = 5'h01;

    // comparator operators
    typedef enum logic [1:0] {
        EAS_CMP_LT,
        EAS_CMP_EQ,
        EAS_CMP_GT
    } eas_cmp_op_t;

    // logic rule operators (applied left to right)
    typedef enum logic [1:0] {
        EAS_LOP_AND,
        EAS_LOP_OR,
        EAS_LOP_AND_NOT,
        EAS_LOP_OR_NOT
    } eas_lop_t;

    // event source classes
    typedef enum logic [1:0] {
        EAS_SRC_STATUS,
        EAS_SRC_LOGIC,
        EAS_SRC_CMP,
        EAS_SRC_FALSE
    } eas_src_kind_t;
endpackage

// file: rtl/eas_comparator.sv
// eas_comparator: one continuous quantity against a fixed preset
// assumes: value and preset from logic on the same clock
`timescale 1ns/1ps
module eas_comparator
    import eas_pkg::*;
#(
    parameter int VAL_W = EAS_VAL_W
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [VAL_W-1:0] value_in,
    input wire logic [VAL_W-1:0] preset_in,
    input wire logic [1:0] op_in,
    output logic result_out
);
    logic result_r;
    logic result_nxt;

    always_comb begin
        unique case (op_in)
            EAS_CMP_LT: result_nxt = value_in < preset_in; // RULE8
            EAS_CMP_EQ: result_nxt = value_in == preset_in; // RULE8
            EAS_CMP_GT: result_nxt = value_in > preset_in; // RULE8
            default: result_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
        end
    end

    assign result_out = result_r;
endmodule

// file: rtl/eas_logic_rule.sv
// eas_logic_rule: combines three boolean inputs with two operators
// assumes: inputs already in the clock domain
`timescale 1ns/1ps
module eas_logic_rule
    import eas_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [EAS_LR_IN-1:0] bits_in,
    input wire logic [1:0] op1_in,
    input wire logic [1:0] op2_in,
    output logic result_out
);
    logic result_r;
    logic result_nxt;

    function automatic logic apply(input logic a, input logic b, input logic [1:0] op);
        unique case (op)
            EAS_LOP_AND: apply = a & b;
            EAS_LOP_OR: apply = a | b;
            EAS_LOP_AND_NOT: apply = a & ~b;
            default: apply = a | ~b;
        endcase
    endfunction

    always_comb begin
        result_nxt = apply(apply(bits_in[0], bits_in[1], op1_in), bits_in[2], op2_in); // RULE9
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
        end
    end

    assign result_out = result_r;
endmodule

// file: rtl/eas_sequencer.sv
// eas_sequencer: scan-driven event/action sequencer with comparators and logic rules
// assumes: status pins are asynchronous; program tables are static configuration from same-clock logic
//
// How it works
// RULE1: event and action share one index
// RULE2: after action, evaluate next index event
// RULE3: exactly one event condition tested at once
// RULE4: false event: nothing happens this scan
// RULE5: start tests only event zero each scan
// RULE6: one to twenty pairs programmable
// RULE7: after last pair wrap to zero
// RULE8: comparator checks quantity against fixed preset
// RULE9: logic rule: up to three inputs, AND/OR/NOT
// RULE10: event selects status, logic rule, or comparator
// RULE11: one evaluation per scan tick; reset zeroes index
`timescale 1ns/1ps
module eas_sequencer
    import eas_pkg::*;
#(
    parameter int SCAN_CYC = EAS_SCAN_CYC
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic [EAS_IDX_W-1:0] num_pairs_in,
    input wire logic [EAS_STAT_W-1:0] status_in,
    input wire logic [EAS_NUM_CMP*EAS_VAL_W-1:0] cmp_value_in,
    input wire logic [EAS_NUM_CMP*EAS_VAL_W-1:0] cmp_preset_in,
    input wire logic [EAS_NUM_CMP*2-1:0] cmp_op_in,
    input wire logic [EAS_NUM_LR*EAS_LR_IN*EAS_SRC_W-1:0] lr_sel_in,
    input wire logic [EAS_NUM_LR*4-1:0] lr_op_in,
    input wire logic [EAS_MAX_PAIRS*EAS_SRC_W-1:0] event_sel_in,
    input wire logic [EAS_MAX_PAIRS*EAS_ACT_W-1:0] action_code_in,
    output logic [EAS_IDX_W-1:0] index_out,
    output logic action_valid_out,
    output logic [EAS_ACT_W-1:0] action_code_out,
    output logic [EAS_IDX_W-1:0] action_index_out,
    output logic scan_tick_out
);
    // ----------------------------------------
    // status synchroniser
    // ----------------------------------------
    logic [EAS_STAT_W-1:0] stat_meta_r;
    logic [EAS_STAT_W-1:0] stat_r;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stat_meta_r <= '0;
            stat_r <= '0;
        end else begin
            stat_meta_r <= status_in;
            stat_r <= stat_meta_r;
        end
    end

    // ----------------------------------------
    // comparators and logic rules
    // ----------------------------------------
    logic [EAS_NUM_CMP-1:0] cmp_res;
    logic [EAS_NUM_LR-1:0] lr_res;
    logic [EAS_NUM_LR*EAS_LR_IN-1:0] lr_bits;
    logic cur_event;

    // source code: 0..7 status, 8..11 comparator, 12..15 logic rule,
    // 16 current event, others false
    localparam logic [EAS_SRC_W-1:0] SRC_CMP_BASE = 5'h08;
    localparam logic [EAS_SRC_W-1:0] SRC_LR_BASE = 5'h0C;
    localparam logic [EAS_SRC_W-1:0] SRC_EVENT = 5'h10;

    function automatic logic pick_src(input logic [EAS_SRC_W-1:0] sel,
                                      input logic [EAS_STAT_W-1:0] st,
                                      input logic [EAS_NUM_CMP-1:0] cm,
                                      input logic [EAS_NUM_LR-1:0] lr,
                                      input logic ev);
        if (sel < SRC_CMP_BASE) begin
            pick_src = st[sel[2:0]];
        end else if (sel < SRC_LR_BASE) begin
            pick_src = cm[sel[1:0]];
        end else if (sel < SRC_EVENT) begin
            pick_src = lr[sel[1:0]];
        end else if (sel == SRC_EVENT) begin
            pick_src = ev;
        end else begin
            pick_src = 1'b0;
        end
    endfunction

    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < EAS_NUM_CMP; gi++) begin : g_cmp
            eas_comparator #(.VAL_W(EAS_VAL_W)) u_cmp (
                .clock_in(clock_in),
                .reset_n_in(reset_n_in),
                .value_in(cmp_value_in[gi*EAS_VAL_W +: EAS_VAL_W]),
                .preset_in(cmp_preset_in[gi*EAS_VAL_W +: EAS_VAL_W]),
                .op_in(cmp_op_in[gi*2 +: 2]),
                .result_out(cmp_res[gi])
            );
        end
        for (gi = 0; gi < EAS_NUM_LR; gi++) begin : g_lr
            for (gj = 0; gj < EAS_LR_IN; gj++) begin : g_in
                // lr inputs may not reference logic rules (no loops)
                assign lr_bits[gi*EAS_LR_IN+gj] = pick_src(
                    lr_sel_in[(gi*EAS_LR_IN+gj)*EAS_SRC_W +: EAS_SRC_W],
                    stat_r, cmp_res, '0, cur_event); // RULE9
            end
            eas_logic_rule u_lr (
                .clock_in(clock_in),
                .reset_n_in(reset_n_in),
                .bits_in(lr_bits[gi*EAS_LR_IN +: EAS_LR_IN]),
                .op1_in(lr_op_in[gi*4 +: 2]),
                .op2_in(lr_op_in[gi*4+2 +: 2]),
                .result_out(lr_res[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // scan divider
    // ----------------------------------------
    localparam int TICK_W = $clog2(SCAN_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SCAN_CYC - 1);
    logic [TICK_W-1:0] tick_cnt_r;
    logic [TICK_W-1:0] tick_cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        tick_cnt_nxt = tick_cnt_r + TICK_W'(1);
        if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_nxt = '0;
            tick_nxt = 1'b1; // RULE11
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    typedef enum logic [0:0] {
        EAS_ST_IDLE,
        EAS_ST_RUN
    } eas_state_t;

    eas_state_t state_r;
    eas_state_t state_nxt;
    logic [EAS_IDX_W-1:0] idx_r;
    logic [EAS_IDX_W-1:0] idx_nxt;
    logic act_valid_r;
    logic act_valid_nxt;
    logic [EAS_ACT_W-1:0] act_code_r;
    logic [EAS_ACT_W-1:0] act_code_nxt;
    logic [EAS_IDX_W-1:0] act_idx_r;
    logic [EAS_IDX_W-1:0] act_idx_nxt;
    logic [EAS_IDX_W-1:0] last_idx;

    // only the current index's selector is looked at
    assign cur_event = pick_src(event_sel_in[idx_r*EAS_SRC_W +: EAS_SRC_W],
                                stat_r, cmp_res, lr_res, 1'b0); // RULE3 RULE10

    // clamp count to 1..20 so a bad setting cannot stall the index
    always_comb begin
        if (num_pairs_in == EAS_IDX_ZERO) begin
            last_idx = EAS_IDX_ZERO;
        end else if (num_pairs_in > EAS_IDX_W'(EAS_MAX_PAIRS)) begin
            last_idx = EAS_IDX_W'(EAS_MAX_PAIRS - 1);
        end else begin
            last_idx = num_pairs_in - EAS_IDX_ONE; // RULE6
        end
    end

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        act_valid_nxt = 1'b0; // RULE4
        act_code_nxt = act_code_r;
        act_idx_nxt = act_idx_r;
        unique case (state_r)
            EAS_ST_IDLE: begin
                idx_nxt = EAS_IDX_ZERO; // RULE5
                if (enable_in) begin
                    state_nxt = EAS_ST_RUN;
                end
            end
            EAS_ST_RUN: begin
                if (!enable_in) begin
                    state_nxt = EAS_ST_IDLE;
                    idx_nxt = EAS_IDX_ZERO;
                end else if (tick_r && cur_event) begin
                    act_valid_nxt = 1'b1;
                    act_code_nxt = action_code_in[idx_r*EAS_ACT_W +: EAS_ACT_W]; // RULE1
                    act_idx_nxt = idx_r;
                    if (idx_r >= last_idx) begin
                        idx_nxt = EAS_IDX_ZERO; // RULE7
                    end else begin
                        idx_nxt = idx_r + EAS_IDX_ONE; // RULE2
                    end
                end
                // false event: index and action stay put
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= EAS_ST_IDLE;
            idx_r <= EAS_IDX_ZERO; // RULE11
            act_valid_r <= 1'b0;
            act_code_r <= '0;
            act_idx_r <= EAS_IDX_ZERO;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            act_valid_r <= act_valid_nxt;
            act_code_r <= act_code_nxt;
            act_idx_r <= act_idx_nxt;
        end
    end

    assign index_out = idx_r;
    assign action_valid_out = act_valid_r;
    assign action_code_out = act_code_r;
    assign action_index_out = act_idx_r;
    assign scan_tick_out = tick_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_pair_match;
        @(posedge clock_in) disable iff (!reset_n_in)
        (state_r == EAS_ST_RUN && enable_in && tick_r && cur_event) |=> (act_valid_r && act_idx_r == $past(idx_r));
    endproperty
    a_pair_match: assert property (p_pair_match) else $error("action index differs from event index"); // RULE1

    property p_advance;
        @(posedge clock_in) disable iff (!reset_n_in)
        (act_valid_r && act_idx_r < last_idx && enable_in) |-> (idx_r == act_idx_r + EAS_IDX_ONE);
    endproperty
    a_advance: assert property (p_advance) else $error("index did not advance after action"); // RULE2

    property p_only_on_tick;
        @(posedge clock_in) disable iff (!reset_n_in)
        act_valid_r |-> $past(tick_r);
    endproperty
    a_only_on_tick: assert property (p_only_on_tick) else $error("action outside scan tick"); // RULE11

    property p_false_hold;
        @(posedge clock_in) disable iff (!reset_n_in)
        (state_r == EAS_ST_RUN && enable_in && !cur_event) |=> (!act_valid_r && $stable(idx_r));
    endproperty
    a_false_hold: assert property (p_false_hold) else $error("false event changed state"); // RULE4

    property p_start_zero;
        @(posedge clock_in) disable iff (!reset_n_in)
        (state_r == EAS_ST_IDLE) |=> (idx_r == EAS_IDX_ZERO);
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("start not at index zero"); // RULE5

    property p_bound;
        @(posedge clock_in) disable iff (!reset_n_in)
        idx_r <= last_idx || !enable_in || $changed(num_pairs_in);
    endproperty
    a_bound: assert property (p_bound) else $error("index beyond programmed pairs"); // RULE6

    property p_wrap;
        @(posedge clock_in) disable iff (!reset_n_in)
        (act_valid_r && act_idx_r >= last_idx) |-> (idx_r == EAS_IDX_ZERO);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap after last pair"); // RULE7

    property p_tick_period;
        @(posedge clock_in) disable iff (!reset_n_in)
        tick_r |=> !tick_r;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("scan tick too wide"); // RULE11

    c_action: cover property (@(posedge clock_in) disable iff (!reset_n_in) act_valid_r);
    c_wrap: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        act_valid_r && idx_r == EAS_IDX_ZERO && act_idx_r != EAS_IDX_ZERO);
    c_false: cover property (@(posedge clock_in) disable iff (!reset_n_in)
        state_r == EAS_ST_RUN && tick_r && !cur_event);
endmodule

// file: test/event_action_sequencer_bench.sv
// event_action_sequencer_bench: self-checking bench for eas_sequencer
// assumes: eas_pkg compiled first; scan interval shortened to 4 cycles
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module event_action_sequencer_bench;
    import eas_pkg::*;
    localparam int SCAN = 4;
    logic clock_in, reset_n_in, enable_in;
    logic [EAS_IDX_W-1:0] num_pairs_in;
    logic [EAS_STAT_W-1:0] status_in;
    logic [EAS_NUM_CMP*EAS_VAL_W-1:0] cmp_value_in, cmp_preset_in;
    logic [EAS_NUM_CMP*2-1:0] cmp_op_in;
    logic [EAS_NUM_LR*EAS_LR_IN*EAS_SRC_W-1:0] lr_sel_in;
    logic [EAS_NUM_LR*4-1:0] lr_op_in;
    logic [EAS_MAX_PAIRS*EAS_SRC_W-1:0] event_sel_in;
    logic [EAS_MAX_PAIRS*EAS_ACT_W-1:0] action_code_in;
    logic [EAS_IDX_W-1:0] index_out, action_index_out;
    logic action_valid_out, scan_tick_out;
    logic [EAS_ACT_W-1:0] action_code_out;
    int miscompares = 0;
    int n_checks = 0;

    eas_sequencer #(.SCAN_CYC(SCAN)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
        .num_pairs_in(num_pairs_in), .status_in(status_in), .cmp_value_in(cmp_value_in),
        .cmp_preset_in(cmp_preset_in), .cmp_op_in(cmp_op_in), .lr_sel_in(lr_sel_in), .lr_op_in(lr_op_in),
        .event_sel_in(event_sel_in), .action_code_in(action_code_in), .index_out(index_out),
        .action_valid_out(action_valid_out), .action_code_out(action_code_out),
        .action_index_out(action_index_out), .scan_tick_out(scan_tick_out));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic settle();
        repeat (8) @(negedge clock_in);
    endtask

    // bounded wait for one action, then judge pairing and next index
    task automatic wait_act(input int idx, input int nidx);
        int k;
        k = 0;
        do begin
            @(negedge clock_in);
            k++;
        end while (action_valid_out !== 1'b1 && k < 40);
        `CHK(action_valid_out, 1'b1, "no action")
        `CHK(action_index_out, idx[4:0], "action index")
        `CHK(action_code_out, 8'h40 + idx[7:0], "action code")
        `CHK(index_out, nidx[4:0], "next index")
    endtask

    task automatic no_act(input int cyc, input int idx);
        int c;
        c = 0;
        repeat (cyc) begin
            @(negedge clock_in);
            if (action_valid_out !== 1'b0) c++;
        end
        `CHK(c, 0, "unexpected action")
        `CHK(index_out, idx[4:0], "index moved")
    endtask

    task automatic cfg(input int n);
        @(posedge clock_in);
        num_pairs_in <= n[4:0];
        for (int i = 0; i < EAS_MAX_PAIRS; i++) begin
            event_sel_in[5*i+:5] <= (i < n) ? 5'(i % 8) : 5'h11;
        end
    endtask

    // idle through enable low so each test starts from index zero
    task automatic stop();
        @(posedge clock_in);
        enable_in <= 1'b0;
        status_in <= 8'h00;
        settle();
        `CHK(index_out, 5'h00, "enable low index")
        @(posedge clock_in);
        enable_in <= 1'b1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle();
        int n;
        @(negedge clock_in);
        `CHK(index_out, 5'h00, "reset index")
        `CHK(action_valid_out, 1'b0, "reset valid")
        `CHK(action_code_out, 8'h00, "reset code")
        n = 0;
        while (scan_tick_out !== 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
        end
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (scan_tick_out !== 1'b1 && n < 40);
        `CHK(n, SCAN, "tick period")
        cfg(3);
        no_act(24, 0);
        $display("idle done");
    endtask

    task automatic t_order();
        @(posedge clock_in);
        status_in <= 8'h06;
        settle();
        no_act(24, 0);
        @(posedge clock_in);
        status_in <= 8'h07;
        wait_act(0, 1);
        wait_act(1, 2);
        wait_act(2, 0);
        wait_act(0, 1);
        stop();
        $display("order done");
    endtask

    task automatic t_count();
        cfg(20);
        @(posedge clock_in);
        status_in <= 8'hFF;
        for (int i = 0; i < 20; i++) wait_act(i, (i + 1) % 20);
        wait_act(0, 1);
        stop();
        cfg(1);
        @(posedge clock_in);
        status_in <= 8'h01;
        wait_act(0, 0);
        wait_act(0, 0);
        stop();
        $display("count done");
    endtask

    task automatic t_cmp();
        logic [15:0] fv[4], tv[4];
        fv = '{16'h0009, 16'h0004, 16'h0005, 16'h0009};
        tv = '{16'h0003, 16'h0005, 16'h0006, 16'h0005};
        @(posedge clock_in);
        event_sel_in[4:0] <= 5'h08;
        cmp_preset_in[15:0] <= 16'h0005;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock_in);
            cmp_op_in[1:0] <= 2'(k);
            cmp_value_in[15:0] <= fv[k];
            settle();
            no_act(16, 0);
            @(posedge clock_in);
            cmp_value_in[15:0] <= tv[k];
            if (k < 3) wait_act(0, 0);
            else no_act(16, 0);
        end
        stop();
        $display("cmp done");
    endtask

    task automatic t_logic();
        @(posedge clock_in);
        event_sel_in[4:0] <= 5'h0C;
        lr_sel_in[14:0] <= {5'h02, 5'h01, 5'h00};
        lr_op_in[3:0] <= 4'h8;
        status_in <= 8'h07;
        settle();
        no_act(16, 0);
        @(posedge clock_in);
        status_in <= 8'h03;
        wait_act(0, 0);
        stop();
        @(posedge clock_in);
        lr_op_in[3:0] <= 4'h5;
        settle();
        no_act(16, 0);
        @(posedge clock_in);
        status_in <= 8'h04;
        wait_act(0, 0);
        stop();
        @(posedge clock_in);
        lr_op_in[3:0] <= 4'h3;
        status_in <= 8'h06;
        settle();
        no_act(16, 0);
        @(posedge clock_in);
        status_in <= 8'h04;
        wait_act(0, 0);
        stop();
        $display("logic done");
    endtask

    task automatic t_reset();
        cfg(3);
        @(posedge clock_in);
        status_in <= 8'h01;
        wait_act(0, 1);
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        @(negedge clock_in);
        `CHK(index_out, 5'h00, "mid reset index")
        `CHK(action_code_out, 8'h00, "mid reset code")
        `CHK(action_index_out, 5'h00, "mid reset action index")
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
        status_in <= 8'h07;
        wait_act(0, 1);
        stop();
        $display("reset done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    initial begin
        #(20000 * 4);
        miscompares++;
        close_out();
    end

    initial begin
        reset_n_in = 1'b0;
        enable_in = 1'b0;
        num_pairs_in = 5'h01;
        status_in = 8'h00;
        cmp_value_in = '0;
        cmp_preset_in = '0;
        cmp_op_in = '1;
        lr_sel_in = '1;
        lr_op_in = '0;
        event_sel_in = '1;
        for (int i = 0; i < EAS_MAX_PAIRS; i++) action_code_in[8*i+:8] = 8'h40 + 8'(i);
        repeat (20) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        enable_in <= 1'b1;
        t_idle();
        t_order();
        t_count();
        t_cmp();
        t_logic();
        t_reset();
        close_out();
    end
endmodule
